// file: include/bwio_pkg.sv
// Package with register map, reset values and pad bundle for the byte-wide I/O ports
package bwio_pkg;
  localparam int NUM_PORTS = 5;
  localparam int PORT_W = 8;
  // Data-space offsets per port, in order A, B, C, D, E
  localparam logic [7:0] LATCH_ADDR [NUM_PORTS] = '{8'hc0, 8'hc1, 8'hc2, 8'hc3, 8'hfc};
  localparam logic [7:0] DIR_ADDR [NUM_PORTS] = '{8'hc4, 8'hc5, 8'hc6, 8'hc7, 8'hfd};
  localparam logic [7:0] OPT_ADDR [NUM_PORTS] = '{8'hcc, 8'hcd, 8'hce, 8'hcf, 8'hfe};
  localparam logic [7:0] POL_ADDR = 8'hda;
  // Polarity bit position of each port A, B, C, D, E
  localparam int POL_BIT [NUM_PORTS] = '{1, 0, 2, 3, 4};
  localparam int POL_W = 5;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [POL_W-1:0] POL_RESET = 5'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  // Lines with a path to the converter multiplexer, per port
  localparam logic [7:0] ANALOG_CAP [NUM_PORTS] = '{8'hf0, 8'hf9, 8'he0, 8'hff, 8'h00};
  // Per-port pad controls
  typedef struct packed {
    logic [7:0] drive;
    logic [7:0] oe;
    logic [7:0] pull;
    logic [7:0] analog;
  } bwio_pad_t;
endpackage

// file: verif/bwio_pin_model.sv
// Pin model: pad drivers, pull-ups and an outside source
`timescale 1ns/100ps
module bwio_pin_model (
  input wire logic i_core_clk,
  input bwio_pkg::bwio_pad_t i_pad [bwio_pkg::NUM_PORTS],
  input wire logic [7:0] i_ext_en [bwio_pkg::NUM_PORTS],
  input wire logic [7:0] i_ext_val [bwio_pkg::NUM_PORTS],
  output logic [7:0] o_pin [bwio_pkg::NUM_PORTS]
);
  logic [7:0] flip = 8'h5a;
  // Floating lines toggle so no stable guess can pass
  always @(posedge i_core_clk) flip <= ~flip;
  // Pad drive wins, then outside source, then pull-up
  for (genvar p = 0; p < bwio_pkg::NUM_PORTS; p++) begin : g_p
    assign o_pin[p] = (i_pad[p].oe & i_pad[p].drive)
      | (~i_pad[p].oe & i_ext_en[p] & i_ext_val[p])
      | (~i_pad[p].oe & ~i_ext_en[p] & (i_pad[p].pull | flip));
  end
endmodule

// file: verif/bwio_port_monitor.sv
// Checker for the byte-wide port block
`timescale 1ns/100ps
module bwio_port_monitor (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  input wire logic o_rd_hit,
  input wire logic [bwio_pkg::NUM_PORTS-1:0] i_level_mode,
  input wire logic [7:0] i_pin [bwio_pkg::NUM_PORTS],
  input bwio_pkg::bwio_pad_t o_pad [bwio_pkg::NUM_PORTS],
  input wire logic [bwio_pkg::NUM_PORTS-1:0] o_port_irq
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  // Read of port A latch
  wire logic rd_a = i_rd && i_addr == bwio_pkg::LATCH_ADDR[0];
  read_hit_a: assert property (rd_a |=> o_rd_hit) else $error("no hit");
  unmapped_read_a: assert property (i_rd && i_addr == 8'h10 |=> !o_rd_hit && o_rdata == 8'h00)
    else $error("unmapped read");
  idle_read_a: assert property (!i_rd |=> o_rdata == 8'h00 && !o_rd_hit)
    else $error("idle read");
  reset_pads_a: assert property ($fell(i_rst) |-> o_pad[0].pull == 8'hff &&
    o_pad[0].oe == 8'h00 && o_port_irq == 5'h00) else $error("reset pads");
  analog_cap_a: assert property ((o_pad[0].analog & ~bwio_pkg::ANALOG_CAP[0]) == 8'h00)
    else $error("analog cap");
  analog_excl_a: assert property ((o_pad[3].analog & (o_pad[3].pull | o_pad[3].oe)) == 8'h00)
    else $error("analog mix");
  dir_out_a: assert property (i_wr && i_addr == bwio_pkg::DIR_ADDR[0] && i_wdata == 8'hff
    |=> o_pad[0].pull == 8'h00 && o_pad[0].analog == 8'h00) else $error("dir out");
  irq_pulse_a: assert property (!i_level_mode[0] && o_port_irq[0] |=> !o_port_irq[0])
    else $error("irq pulse");
  // Two sync flops plus the read register
  rd_sync_a: assert property (rd_a && o_pad[0].oe == 8'h00 |=> o_rdata == $past(i_pin[0], 3))
    else $error("rd sync");
  cover property (o_port_irq[3]);
  cover property ($rose(o_port_irq[0]));
  cover property (rd_a && o_pad[0].oe == 8'hcf);
endmodule
bind bwio_port bwio_port_monitor u_mon (.i_core_clk, .i_rst, .i_addr, .i_wr, .i_rd, .i_wdata,
  .o_rdata, .o_rd_hit, .i_level_mode, .i_pin, .o_pad, .o_port_irq);

// file: verif/bwio_port_tb.sv
// Bench for the byte-wide port block
`timescale 1ns/100ps
`define CK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; \
  $display("BAD %0t got %h", $time, g); end end
module bwio_port_tb;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e; logic h;} bwio_row_t;
  logic i_core_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, o_rd_hit;
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata, i_pin [5];
  logic [7:0] ext_en [5] = '{default: 8'h00}, ext_val [5] = '{default: 8'h00};
  logic [4:0] i_level_mode = 5'h00, o_port_irq;
  bwio_pkg::bwio_pad_t o_pad [5];
  int failures = 0, cmp_count = 0, cyc = 0, n;
  bwio_row_t rows [5] = '{'{8'hc4, 8'ha5, 8'ha5, 1'b1}, '{8'hcd, 8'h3c, 8'h3c, 1'b1},
    '{8'hfd, 8'h81, 8'h81, 1'b1}, '{8'hda, 8'hff, 8'h1f, 1'b1}, '{8'h10, 8'hff, 8'h00, 1'b0}};
  bwio_port dut (.i_core_clk, .i_rst, .i_addr, .i_wr, .i_rd, .i_wdata, .o_rdata, .o_rd_hit,
    .i_level_mode, .i_pin, .o_pad, .o_port_irq);
  bwio_pin_model pm (.i_core_clk, .i_pad(o_pad), .i_ext_en(ext_en), .i_ext_val(ext_val),
    .o_pin(i_pin));
  task automatic results;
    if (failures == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Bus cycles: strobe raised for one taken edge
  task automatic wr(input logic [7:0] a, d);
    @(posedge i_core_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, e, input logic h);
    @(posedge i_core_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    // Answer stands only in the cycle after the taken edge
    #1 `CK(o_rdata, e)
    `CK(o_rd_hit, h)
  endtask
  task automatic rst6;
    @(posedge i_core_clk);
    i_rst <= 1'b1;
    repeat (6) @(posedge i_core_clk);
    i_rst <= 1'b0;
  endtask
  initial forever #2.5 i_core_clk = ~i_core_clk;
  // Cut a hang short well past the expected run
  always @(posedge i_core_clk) begin
    cyc++;
    if (cyc == 2000) begin
      failures++;
      results();
    end
  end
  initial begin
    rst6();
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e, rows[i].h);
    end
    rst6();
    rd(8'hc0, 8'hff, 1'b1);
    wr(8'hc0, 8'h35);
    wr(8'hcc, 8'h0f);
    wr(8'hc4, 8'hff);
    rd(8'hc0, 8'h35, 1'b1);
    `CK(o_pad[0].oe, 8'hcf)
    `CK(i_pin[0] & 8'hcf, 8'h05)
    wr(8'hc3, 8'hcc);
    wr(8'hcf, 8'h70);
    #1 `CK(o_pad[3].pull, 8'h33)
    `CK(o_pad[3].analog, 8'h40)
    @(posedge i_core_clk);
    ext_en[3] <= 8'hff;
    ext_val[3] <= 8'hdf;
    i_level_mode <= 5'h08;
    // Pin change needs both sync stages before a read sees it
    repeat (2) @(posedge i_core_clk);
    rd(8'hc3, 8'hdf, 1'b1);
    #1 `CK(o_port_irq[3], 1'b1)
    rst6();
    wr(8'hcc, 8'h01);
    ext_en[0] <= 8'h01;
    n = 0;
    repeat (8) begin
      @(posedge i_core_clk);
      #1 n += o_port_irq[0];
    end
    `CK(n, 1)
    results();
  end
endmodule

// file: verilog/bwio_port.sv
// Byte-wide general-purpose I/O ports with data-space registers
// Overview of operation
// - Each port has data latch, direction and option registers; bit n is line n.
// - Input lines read the sampled pin; output lines read the written latch.
// - Latch writes always land, changing input configuration of input lines.
// - Each direction bit selects input 0 or output 1 for its line.
// - Reset clears all port registers: every line input with pull-up, no interrupt.
// - Direction 0, option 0, latch 0: input with pull-up, no interrupt.
// - Direction 0, option 0, latch 1: input without pull-up, no interrupt.
// - Direction 0, option 1, latch 0: input with pull-up feeding port interrupt.
// - Direction 0, option 1, latch 1: analog input on capable lines.
// - Direction 1, option 0: open-drain output; latch pulls low or releases.
// - Direction 1, option 1: push-pull output driving the latch value.
// - Input without pull-up leaves the pin undriven.
// - Interrupt lines trigger on falling edge, rising edge, low level or high level per port.
// - Polarity bit set inverts the port trigger sense; polarity clears on reset.
`timescale 1ns/100ps
module bwio_port (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  output logic o_rd_hit,
  input wire logic [bwio_pkg::NUM_PORTS-1:0] i_level_mode,
  input wire logic [7:0] i_pin [bwio_pkg::NUM_PORTS],
  output bwio_pkg::bwio_pad_t o_pad [bwio_pkg::NUM_PORTS],
  output logic [bwio_pkg::NUM_PORTS-1:0] o_port_irq
);

  localparam int NP = bwio_pkg::NUM_PORTS;

  // Register state
  logic [7:0] line_value_latch [NP];
  logic [7:0] pin_direction_bits [NP];
  logic [7:0] pin_option_bits [NP];
  logic [bwio_pkg::POL_W-1:0] edge_polarity_invert_bits;

  // Pin synchroniser stages and trigger history
  logic [7:0] pin_meta [NP];
  logic [7:0] pin_sync [NP];
  logic [NP-1:0] trig_prev;
  logic [NP-1:0] trig_now;
  logic [NP-1:0] next_irq;

  // Per-port decode and read values
  logic [NP-1:0] hit_latch;
  logic [NP-1:0] hit_dir;
  logic [NP-1:0] hit_opt;
  logic [7:0] rd_latch [NP];
  logic [7:0] rd_port [NP];
  logic hit_pol;
  logic [7:0] next_rdata;
  logic next_hit;

  assign hit_pol = i_addr == bwio_pkg::POL_ADDR;

  genvar gp;
  generate
    for (gp = 0; gp < NP; gp++) begin : g_port
      logic [7:0] irq_lines;
      logic [7:0] analog_lines;
      logic [7:0] pull_lines;
      logic [7:0] pp_lines;
      logic [7:0] od_lines;
      logic any_low;
      logic sense;

      // Address decode
      assign hit_latch[gp] = i_addr == bwio_pkg::LATCH_ADDR[gp];
      assign hit_dir[gp] = i_addr == bwio_pkg::DIR_ADDR[gp];
      assign hit_opt[gp] = i_addr == bwio_pkg::OPT_ADDR[gp];

      // Outputs read the latch, inputs read the synchronised pin
      assign rd_latch[gp] = (pin_direction_bits[gp] & line_value_latch[gp])
                          | (~pin_direction_bits[gp] & pin_sync[gp]);

      // Per-port read contribution, zero when not addressed
      assign rd_port[gp] = ({8{hit_latch[gp]}} & rd_latch[gp])
                         | ({8{hit_dir[gp]}} & pin_direction_bits[gp])
                         | ({8{hit_opt[gp]}} & pin_option_bits[gp]);

      // Mode decode of direction, option and latch per line
      assign irq_lines = ~pin_direction_bits[gp] & pin_option_bits[gp]
                       & ~line_value_latch[gp];
      assign analog_lines = ~pin_direction_bits[gp] & pin_option_bits[gp]
                          & line_value_latch[gp] & bwio_pkg::ANALOG_CAP[gp];
      assign pull_lines = ~pin_direction_bits[gp] & ~line_value_latch[gp];
      assign pp_lines = pin_direction_bits[gp] & pin_option_bits[gp];
      assign od_lines = pin_direction_bits[gp] & ~pin_option_bits[gp];

      // Push-pull drives always; open-drain only while pulling low
      // One driver per pad bundle keeps each element single-sourced
      assign o_pad[gp] = '{
        drive: pp_lines & line_value_latch[gp],
        oe: pp_lines | (od_lines & ~line_value_latch[gp]),
        pull: pull_lines,
        analog: analog_lines
      };

      // Connected lines are wired-AND; polarity inverts the sense
      assign any_low = |(irq_lines & ~pin_sync[gp]);
      assign sense = any_low ^ edge_polarity_invert_bits[bwio_pkg::POL_BIT[gp]];
      assign trig_now[gp] = sense;
      // Level mode asserts while active; edge mode on activation
      assign next_irq[gp] = i_level_mode[gp] ? sense : (sense & ~trig_prev[gp]);
    end
  endgenerate

  // Read mux across ports
  always_comb begin
    next_rdata = bwio_pkg::RD_UNMAPPED;
    next_hit = hit_pol;
    if (hit_pol) begin
      next_rdata = {3'h0, edge_polarity_invert_bits};
    end
    for (int p = 0; p < NP; p++) begin
      next_rdata = next_rdata | rd_port[p];
      next_hit = next_hit | hit_latch[p] | hit_dir[p] | hit_opt[p];
    end
  end

  // Two-flop pin synchroniser; first stage feeds only the second
  always_ff @(posedge i_core_clk) begin
    for (int p = 0; p < NP; p++) begin
      pin_meta[p] <= i_pin[p];
      pin_sync[p] <= pin_meta[p];
    end
  end

  // Register writes; latch accepts writes regardless of direction
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      for (int p = 0; p < NP; p++) begin
        line_value_latch[p] <= bwio_pkg::REG_RESET;
        pin_direction_bits[p] <= bwio_pkg::REG_RESET;
        pin_option_bits[p] <= bwio_pkg::REG_RESET;
      end
      edge_polarity_invert_bits <= bwio_pkg::POL_RESET;
    end else if (i_wr) begin
      for (int p = 0; p < NP; p++) begin
        if (hit_latch[p]) begin
          line_value_latch[p] <= i_wdata;
        end
        if (hit_dir[p]) begin
          pin_direction_bits[p] <= i_wdata;
        end
        if (hit_opt[p]) begin
          pin_option_bits[p] <= i_wdata;
        end
      end
      if (hit_pol) begin
        edge_polarity_invert_bits <= i_wdata[bwio_pkg::POL_W-1:0];
      end
    end
  end

  // Registered read answer, one cycle after the strobe
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
      o_rd_hit <= 1'b0;
    end else begin
      o_rdata <= i_rd ? next_rdata : 8'h00;
      o_rd_hit <= i_rd & next_hit;
    end
  end

  // Trigger history starts inactive so reset raises no edge
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      trig_prev <= '0;
      o_port_irq <= '0;
    end else begin
      trig_prev <= trig_now;
      o_port_irq <= next_irq;
    end
  end

endmodule
